// File: design/smbcr_params.svh
// constants of the chip-selected serial configuration register port
// included by both ends and the bench; definitions only
//
// Function
// - host raises chip select before any transfer
// - start, address, write bit; device acknowledges
// - index byte acknowledged and latched by device
// - write data byte acknowledged and stored
// - host ends with stop, then drops select
// - read: repeated start, address, read bit, acknowledge
// - device returns indexed register, msb first
// - host answers read byte with not-acknowledge
// - device releases bus once transaction ends
// - read-only ignore writes; read/write return value
// - select low: device ignores all bus traffic
// - acknowledge only slave address 1010110
// - port keeps working during device standby
`ifndef SMBCR_PARAMS_SVH
`define SMBCR_PARAMS_SVH

// ----------------------------------------------------------------
// serial protocol
// ----------------------------------------------------------------
`define SMBCR_SLAVE_ADDR 7'h56
`define SMBCR_BITS_PER_BYTE 4'h8

// ----------------------------------------------------------------
// device register indices and reset values
// ----------------------------------------------------------------
`define SMBCR_IDX_PRESENCE 8'h00
`define SMBCR_IDX_BOOST1_RB 8'h01
`define SMBCR_IDX_BOOST23_RB 8'h02
`define SMBCR_IDX_CLK_LANE0 8'h03
`define SMBCR_IDX_LANE12 8'h04
`define SMBCR_IDX_ON_LEVEL 8'h05
`define SMBCR_IDX_OFF_LEVEL 8'h06
`define SMBCR_IDX_EN_SOURCE 8'h07
`define SMBCR_IDX_SWING 8'h08
`define SMBCR_RST_CLK_LANE0 8'h77
`define SMBCR_RST_LANE12 8'h77
`define SMBCR_RST_ON_LEVEL 8'h00
`define SMBCR_RST_OFF_LEVEL 8'h00
`define SMBCR_RST_EN_SOURCE 8'h00
`define SMBCR_RST_SWING 8'h78

// ----------------------------------------------------------------
// host controller registers (byte offsets on the bus)
// ----------------------------------------------------------------
`define SMBCR_OFS_CTRL 8'h00
`define SMBCR_OFS_INDEX 8'h04
`define SMBCR_OFS_WDATA 8'h08
`define SMBCR_OFS_RDATA 8'h0C
`define SMBCR_OFS_STATUS 8'h10
`define SMBCR_OFS_IRQ_STAT 8'h14
`define SMBCR_OFS_IRQ_MASK 8'h18
`define SMBCR_CTRL_GO 0
`define SMBCR_CTRL_READ 1
`define SMBCR_IRQ_DONE 0
`define SMBCR_IRQ_NACK 1

// ----------------------------------------------------------------
// timing: one quarter of the serial clock period
// ----------------------------------------------------------------
`define SMBCR_CLK_MHZ 200
`define SMBCR_T_QTR_NS 5000
`define SMBCR_QTR_CYC ((`SMBCR_T_QTR_NS * `SMBCR_CLK_MHZ) / 1000)

`endif

// File: design/smbcr_pkg.sv
// types shared by both ends of the serial register port
// assumes nothing beyond a SystemVerilog compiler
package smbcr_pkg;
  typedef logic [7:0] smbcr_byte_t;
  typedef logic [2:0] smbcr_code_t;
  typedef logic [1:0] smbcr_lvl_t;
  typedef enum logic [2:0] {
    DEV_IDLE = 3'h0,
    DEV_ADDR = 3'h1,
    DEV_INDEX = 3'h3,
    DEV_WDATA = 3'h2,
    DEV_RDATA = 3'h6,
    DEV_IGNORE = 3'h4
  } smbcr_dev_st_t;
  typedef enum logic [2:0] {
    HST_IDLE = 3'h0,
    HST_CSU = 3'h1,
    HST_START = 3'h3,
    HST_BYTE = 3'h2,
    HST_STOP = 3'h6,
    HST_CSH = 3'h7
  } smbcr_hst_st_t;
endpackage

// File: design/smbcr_if.sv
// the wires between host and device: select plus two open-drain lines
// line levels are resolved here from the enables (pulled up when free)
`timescale 1ns/1ps
interface smbcr_if;
  logic chip_select;
  logic host_scl_oe;
  logic host_sda_oe;
  logic dev_sda_oe;
  logic serial_clock_line;
  logic serial_data_line;
  assign serial_clock_line = ~host_scl_oe;
  assign serial_data_line = ~(host_sda_oe | dev_sda_oe);
  modport dev (
    input chip_select,
    input serial_clock_line,
    input serial_data_line,
    output dev_sda_oe
  );
  modport host (
    output chip_select,
    output host_scl_oe,
    output host_sda_oe,
    input serial_clock_line,
    input serial_data_line
  );
endinterface

// File: design/smbcr_device.sv
// device end: serial slave holding the nine configuration registers
// assumes line levels come from pins and are asynchronous to sys_clk
`timescale 1ns/1ps
`include "smbcr_params.svh"
module smbcr_device #(
  parameter logic [3:0] REVISION = 4'h1 // arbitrary value
) (
  input wire logic sys_clk,
  input wire logic reset,
  smbcr_if.dev bus,
  input wire logic clock_presence_flag,
  input wire smbcr_pkg::smbcr_code_t applied_boost_ch1,
  input wire smbcr_pkg::smbcr_code_t applied_boost_ch2,
  input wire smbcr_pkg::smbcr_code_t applied_boost_ch3,
  input wire logic applied_enable,
  output smbcr_pkg::smbcr_code_t lane_boost_code0,
  output smbcr_pkg::smbcr_code_t lane_boost_code1,
  output smbcr_pkg::smbcr_code_t lane_boost_code2,
  output logic clock_disable,
  output logic lane0_disable,
  output logic lane1_disable,
  output logic lane2_disable,
  output smbcr_pkg::smbcr_lvl_t presence_assert_level,
  output smbcr_pkg::smbcr_lvl_t presence_deassert_level,
  output logic enable_from_register,
  output smbcr_pkg::smbcr_lvl_t output_swing_code
);
  import smbcr_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers: three stages, change taken when 2 and 3 agree
  // ----------------------------------------------------------------
  logic [13:0] pins;
  logic [13:0] s1_r;
  logic [13:0] s2_r;
  logic [13:0] s3_r;
  logic [13:0] f_r;
  logic [13:0] f_nxt;
  logic [13:0] agree;
  assign pins = {bus.chip_select, bus.serial_clock_line,
                 bus.serial_data_line, clock_presence_flag,
                 applied_enable, applied_boost_ch1,
                 applied_boost_ch2, applied_boost_ch3};
  assign agree = ~(s2_r ^ s3_r);
  assign f_nxt = (agree & s3_r) | (~agree & f_r);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      // lines start at their idle high level: no false edge after reset
      s1_r <= 14'h1800;
      s2_r <= 14'h1800;
      s3_r <= 14'h1800;
      f_r <= 14'h1800;
    end else begin
      s1_r <= pins;
      s2_r <= s1_r;
      s3_r <= s2_r;
      f_r <= f_nxt;
    end
  end

  logic cs_f;
  logic scl_f;
  logic sda_f;
  logic presence_f;
  logic en_f;
  smbcr_code_t boost1_f;
  smbcr_code_t boost2_f;
  smbcr_code_t boost3_f;
  logic scl_q_r;
  logic sda_q_r;
  assign cs_f = f_r[13];
  assign scl_f = f_r[12];
  assign sda_f = f_r[11];
  assign presence_f = f_r[10];
  assign en_f = f_r[9];
  assign boost1_f = f_r[8:6];
  assign boost2_f = f_r[5:3];
  assign boost3_f = f_r[2:0];

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_f;
      sda_q_r <= sda_f;
    end
  end

  // ----------------------------------------------------------------
  // line events
  // ----------------------------------------------------------------
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  assign scl_rise = scl_f & ~scl_q_r;
  assign scl_fall = ~scl_f & scl_q_r;
  assign start_seen = scl_f & scl_q_r & sda_q_r & ~sda_f;
  assign stop_seen = scl_f & scl_q_r & ~sda_q_r & sda_f;

  // ----------------------------------------------------------------
  // serial state machine
  // ----------------------------------------------------------------
  smbcr_dev_st_t st_r;
  logic [3:0] cnt_r;
  logic ack_r;
  logic rw_r;
  logic oe_r;
  smbcr_byte_t sh_r;
  smbcr_byte_t tx_r;
  smbcr_byte_t index_r;
  smbcr_byte_t rd_data;

  logic full_byte;
  logic rx_state;
  logic addr_ok;
  logic ack_begin;
  logic ack_end;
  logic write_hit;
  assign full_byte = (cnt_r == `SMBCR_BITS_PER_BYTE);
  assign rx_state = (st_r == DEV_ADDR) | (st_r == DEV_INDEX) |
                    (st_r == DEV_WDATA);
  assign addr_ok = (sh_r[7:1] == `SMBCR_SLAVE_ADDR);
  assign ack_begin = scl_fall & full_byte & ~ack_r & rx_state;
  assign ack_end = scl_fall & ack_r;
  // only indices 3..8 hold storage; others are read-only or absent
  assign write_hit = cs_f & ack_begin & (st_r == DEV_WDATA) &
                     (index_r >= `SMBCR_IDX_CLK_LANE0) &
                     (index_r <= `SMBCR_IDX_SWING);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_r <= DEV_IDLE;
      cnt_r <= 4'h0;
      ack_r <= 1'b0;
      rw_r <= 1'b0;
      oe_r <= 1'b0;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      index_r <= 8'h00;
    end else if (!cs_f || stop_seen) begin
      // deselected or stopped: let go of the line at once
      st_r <= DEV_IDLE;
      oe_r <= 1'b0;
      ack_r <= 1'b0;
    end else if (start_seen) begin
      st_r <= DEV_ADDR;
      cnt_r <= 4'h0;
      oe_r <= 1'b0;
      ack_r <= 1'b0;
    end else if (scl_rise) begin
      if ((rx_state || st_r == DEV_RDATA) && !full_byte) begin
        sh_r <= {sh_r[6:0], sda_f};
        cnt_r <= cnt_r + 4'h1;
      end else if (st_r == DEV_RDATA && full_byte && !ack_r) begin
        // one byte per read; the host's answer ends our part
        st_r <= DEV_IGNORE;
      end
    end else if (ack_begin) begin
      ack_r <= 1'b1;
      if (st_r == DEV_ADDR) begin
        oe_r <= addr_ok;
        rw_r <= sh_r[0];
        if (!addr_ok) begin
          st_r <= DEV_IGNORE;
        end
      end else begin
        oe_r <= 1'b1;
        if (st_r == DEV_INDEX) begin
          index_r <= sh_r;
        end
      end
    end else if (ack_end) begin
      ack_r <= 1'b0;
      cnt_r <= 4'h0;
      oe_r <= 1'b0;
      if (st_r == DEV_ADDR && rw_r) begin
        st_r <= DEV_RDATA;
        tx_r <= rd_data;
        oe_r <= ~rd_data[7];
      end else if (st_r == DEV_ADDR) begin
        st_r <= DEV_INDEX;
      end else if (st_r == DEV_INDEX) begin
        st_r <= DEV_WDATA;
      end else begin
        st_r <= DEV_IGNORE;
      end
    end else if (scl_fall && st_r == DEV_RDATA) begin
      if (full_byte) begin
        oe_r <= 1'b0; // free the line for the host's answer
      end else if (cnt_r != 4'h0) begin
        tx_r <= {tx_r[6:0], 1'b0};
        oe_r <= ~tx_r[6];
      end
    end
  end

  assign bus.dev_sda_oe = oe_r;

  // ----------------------------------------------------------------
  // register storage, indexed 3..8; runs regardless of standby
  // ----------------------------------------------------------------
  smbcr_byte_t regs_r [3:8];
  logic [3:0] wr_idx;
  assign wr_idx = index_r[3:0];

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      regs_r[3] <= `SMBCR_RST_CLK_LANE0;
      regs_r[4] <= `SMBCR_RST_LANE12;
      regs_r[5] <= `SMBCR_RST_ON_LEVEL;
      regs_r[6] <= `SMBCR_RST_OFF_LEVEL;
      regs_r[7] <= `SMBCR_RST_EN_SOURCE;
      regs_r[8] <= `SMBCR_RST_SWING;
    end else if (write_hit) begin
      regs_r[wr_idx] <= sh_r;
    end
  end

  smbcr_byte_t stat0;
  smbcr_byte_t stat1;
  smbcr_byte_t stat2;
  logic rd_rw_hit;
  assign stat0 = {REVISION, 3'h0, presence_f};
  assign stat1 = {1'b0, boost1_f, en_f, 3'h0};
  assign stat2 = {1'b0, boost3_f, 1'b0, boost2_f};
  assign rd_rw_hit = (index_r >= `SMBCR_IDX_CLK_LANE0) &&
                     (index_r <= `SMBCR_IDX_SWING);
  assign rd_data = (index_r == `SMBCR_IDX_PRESENCE) ? stat0 :
                   (index_r == `SMBCR_IDX_BOOST1_RB) ? stat1 :
                   (index_r == `SMBCR_IDX_BOOST23_RB) ? stat2 :
                   rd_rw_hit ? regs_r[wr_idx] : 8'h00;

  // ----------------------------------------------------------------
  // fields towards the analog side
  // ----------------------------------------------------------------
  assign lane0_disable = regs_r[3][7];
  assign lane_boost_code0 = regs_r[3][6:4];
  assign clock_disable = regs_r[3][3];
  assign lane2_disable = regs_r[4][7];
  assign lane_boost_code2 = regs_r[4][6:4];
  assign lane1_disable = regs_r[4][3];
  assign lane_boost_code1 = regs_r[4][2:0];
  assign presence_assert_level = regs_r[5][1:0];
  assign presence_deassert_level = regs_r[6][1:0];
  assign enable_from_register = regs_r[7][0];
  assign output_swing_code = regs_r[8][3:2];
endmodule

// File: design/smbcr_host.sv
// host end: AHB-Lite controlled serial master with chip select
// assumes a single AHB-Lite master; one register access per command
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "smbcr_params.svh"
module smbcr_host #(
  parameter int QTR_CYC = `SMBCR_QTR_CYC
) (
  input wire logic sys_clk,
  input wire logic reset,
  smbcr_if.host bus,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq
);
  import smbcr_pkg::*;

  // ----------------------------------------------------------------
  // bus slave: zero wait states, read data registered at address
  // ----------------------------------------------------------------
  logic wr_pend_r;
  logic [7:0] wr_ofs_r;
  logic [1:0] irq_stat_r;
  logic [1:0] irq_mask_r;
  smbcr_byte_t index_r;
  smbcr_byte_t wdata_r;
  smbcr_byte_t rdata_r;
  smbcr_hst_st_t st_r;
  logic nack_r;
  logic take;
  logic busy;
  logic [31:0] rd_mux;
  assign take = hsel & htrans[1] & hready;
  assign busy = (st_r != HST_IDLE);
  assign rd_mux =
    (haddr[7:0] == `SMBCR_OFS_INDEX) ? {24'h0, index_r} :
    (haddr[7:0] == `SMBCR_OFS_WDATA) ? {24'h0, wdata_r} :
    (haddr[7:0] == `SMBCR_OFS_RDATA) ? {24'h0, rdata_r} :
    (haddr[7:0] == `SMBCR_OFS_STATUS) ? {30'h0, nack_r, busy} :
    (haddr[7:0] == `SMBCR_OFS_IRQ_STAT) ? {30'h0, irq_stat_r} :
    (haddr[7:0] == `SMBCR_OFS_IRQ_MASK) ? {30'h0, irq_mask_r} :
    32'h0;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = |(irq_stat_r & irq_mask_r);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wr_pend_r <= 1'b0;
      wr_ofs_r <= 8'h00;
      hrdata <= 32'h0;
    end else begin
      wr_pend_r <= take & hwrite;
      wr_ofs_r <= haddr[7:0];
      if (take && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  logic wr_ctrl;
  logic go;
  logic done_ev;
  logic nack_ev;
  logic [1:0] clr;
  assign wr_ctrl = wr_pend_r & (wr_ofs_r == `SMBCR_OFS_CTRL);
  assign go = wr_ctrl & hwdata[`SMBCR_CTRL_GO] & ~busy;
  assign clr = (wr_pend_r && wr_ofs_r == `SMBCR_OFS_IRQ_STAT) ?
               hwdata[1:0] : 2'h0;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      index_r <= 8'h00;
      wdata_r <= 8'h00;
      irq_mask_r <= 2'h0;
      irq_stat_r <= 2'h0;
    end else begin
      if (wr_pend_r && wr_ofs_r == `SMBCR_OFS_INDEX && !busy) begin
        index_r <= hwdata[7:0];
      end
      if (wr_pend_r && wr_ofs_r == `SMBCR_OFS_WDATA && !busy) begin
        wdata_r <= hwdata[7:0];
      end
      if (wr_pend_r && wr_ofs_r == `SMBCR_OFS_IRQ_MASK) begin
        irq_mask_r <= hwdata[1:0];
      end
      // a new event outranks a clear in the same cycle
      irq_stat_r <= (irq_stat_r & ~clr) | {nack_ev, done_ev};
    end
  end

  // ----------------------------------------------------------------
  // data line sampler: three stages, change taken when 2 and 3 agree
  // ----------------------------------------------------------------
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic sda_f_r;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      sda_f_r <= 1'b1;
    end else begin
      s1_r <= bus.serial_data_line;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        sda_f_r <= s3_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // quarter-bit enable from a divider
  // ----------------------------------------------------------------
  logic [15:0] div_r;
  logic tick;
  assign tick = busy & (div_r == 16'(QTR_CYC - 1));
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      div_r <= 16'h0;
    end else begin
      div_r <= (tick || !busy) ? 16'h0 : div_r + 16'h1;
    end
  end

  // ----------------------------------------------------------------
  // transfer sequencer; quarters: 0 set data, 1 rise, 2 sample, 3 fall
  // ----------------------------------------------------------------
  logic [1:0] q_r;
  logic [3:0] bit_r;
  logic [1:0] seq_r;
  logic rd_op_r;
  logic cs_r;
  logic scl_oe_r;
  logic sda_oe_r;
  smbcr_byte_t tx_r;
  smbcr_byte_t rx_r;
  logic rcv;
  logic last_bit;
  assign rcv = rd_op_r & (seq_r == 2'h3);
  assign last_bit = (bit_r == `SMBCR_BITS_PER_BYTE);
  assign done_ev = tick & (st_r == HST_CSH);
  assign nack_ev = done_ev & nack_r;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_r <= HST_IDLE;
      q_r <= 2'h0;
      bit_r <= 4'h0;
      seq_r <= 2'h0;
      rd_op_r <= 1'b0;
      nack_r <= 1'b0;
      cs_r <= 1'b0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      tx_r <= 8'h00;
      rx_r <= 8'h00;
      rdata_r <= 8'h00;
    end else if (go) begin
      st_r <= HST_CSU;
      cs_r <= 1'b1;
      rd_op_r <= hwdata[`SMBCR_CTRL_READ];
      nack_r <= 1'b0;
      seq_r <= 2'h0;
      q_r <= 2'h0;
      tx_r <= {`SMBCR_SLAVE_ADDR, 1'b0};
    end else if (tick) begin
      q_r <= q_r + 2'h1;
      case (st_r)
        HST_CSU: begin
          st_r <= HST_START;
          q_r <= 2'h0;
        end
        HST_START: begin
          if (q_r == 2'h0) sda_oe_r <= 1'b0;
          if (q_r == 2'h1) scl_oe_r <= 1'b0;
          if (q_r == 2'h2) sda_oe_r <= 1'b1;
          if (q_r == 2'h3) begin
            scl_oe_r <= 1'b1;
            st_r <= HST_BYTE;
            bit_r <= 4'h0;
          end
        end
        HST_BYTE: begin
          if (q_r == 2'h0) begin
            // receive bits and the closing not-acknowledge float
            sda_oe_r <= ~rcv & ~last_bit & ~tx_r[3'h7 - bit_r[2:0]];
          end
          if (q_r == 2'h1) scl_oe_r <= 1'b0;
          if (q_r == 2'h2) begin
            if (!last_bit) rx_r <= {rx_r[6:0], sda_f_r};
            if (last_bit && !rcv && sda_f_r) nack_r <= 1'b1;
          end
          if (q_r == 2'h3) begin
            scl_oe_r <= 1'b1;
            bit_r <= bit_r + 4'h1;
            if (last_bit) begin
              seq_r <= seq_r + 2'h1;
              bit_r <= 4'h0;
              if (nack_r || seq_r == 2'h3 ||
                  (seq_r == 2'h2 && !rd_op_r)) begin
                st_r <= HST_STOP;
              end else if (seq_r == 2'h1 && rd_op_r) begin
                st_r <= HST_START;
                tx_r <= {`SMBCR_SLAVE_ADDR, 1'b1};
              end
              if (seq_r == 2'h0) tx_r <= index_r;
              if (seq_r == 2'h1 && !rd_op_r) tx_r <= wdata_r;
              if (seq_r == 2'h2 && rd_op_r) seq_r <= 2'h3;
              if (seq_r == 2'h3) rdata_r <= rx_r;
            end
          end
        end
        HST_STOP: begin
          if (q_r == 2'h0) sda_oe_r <= 1'b1;
          if (q_r == 2'h1) scl_oe_r <= 1'b0;
          if (q_r == 2'h2) sda_oe_r <= 1'b0;
          if (q_r == 2'h3) st_r <= HST_CSH;
        end
        HST_CSH: begin
          cs_r <= 1'b0;
          st_r <= HST_IDLE;
        end
        default: st_r <= HST_IDLE;
      endcase
    end
  end

  assign bus.chip_select = cs_r;
  assign bus.host_scl_oe = scl_oe_r;
  assign bus.host_sda_oe = sda_oe_r;
endmodule

// File: sim/smbcr_asserts.sv
// wire checks between the host and device ends of the register port
// assumes one clock domain; lines are the interface's resolved levels
`timescale 1ns/1ps
module smbcr_asserts (
  input logic sys_clk,
  input logic reset,
  input logic chip_select,
  input logic host_scl_oe,
  input logic host_sda_oe,
  input logic dev_sda_oe,
  input logic serial_clock_line,
  input logic serial_data_line
);
  wire scl = serial_clock_line;
  wire sda = serial_data_line;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // ---------------------------------------------
  // wire rules
  // ---------------------------------------------
  a_host_quiet_off: assert property (
    !chip_select |-> !host_scl_oe && !host_sda_oe)
    else $error("host drives lines while deselected");
  a_select_setup: assert property (
    $fell(sda) && scl |-> chip_select && $past(chip_select, 4))
    else $error("start without select set up");
  a_stop_deselect: assert property (
    $fell(chip_select) |-> sda && scl && $past(sda, 6) && $past(scl, 6))
    else $error("deselect before stop");
  a_oe_needs_select: assert property (
    dev_sda_oe |-> chip_select)
    else $error("device drives data while deselected");
  a_dev_edge_low: assert property (
    $changed(dev_sda_oe) |-> !scl && !$past(scl, 2))
    else $error("device data changed near clock high");
  a_reset_idle: assert property (
    $fell(reset) |-> !dev_sda_oe && !host_sda_oe && !chip_select)
    else $error("not idle after reset");
  a_free_after_stop: assert property (
    $rose(sda) && scl |=> !dev_sda_oe [*8])
    else $error("device holds data after stop");
  a_drive_bounded: assert property (
    dev_sda_oe |-> ##[1:400] !dev_sda_oe)
    else $error("device never releases data");
  c_dev_ack: cover property ($rose(dev_sda_oe));
  c_deselect: cover property ($fell(chip_select));
  c_dev_low_bit: cover property (dev_sda_oe && scl);
endmodule

// File: sim/test_smbus_config_register_port.sv
// self-checking bench: both ends joined, host driven over AHB-Lite
// assumes quarter period shortened to 8 cycles of sys_clk
`timescale 1ns/1ps
`include "smbcr_params.svh"
module test_smbus_config_register_port;
  import smbcr_pkg::*;
  logic sys_clk = 1'h0;
  logic reset = 1'h1;
  logic hsel = 1'h0, hwrite = 1'h0, flag = 1'h1, en = 1'h1;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, w;
  logic hreadyout, hresp, irq, cdis, l0dis, l1dis, l2dis, efr;
  smbcr_code_t b1 = 3'h5, b2 = 3'h2, b3 = 3'h6, lbc0, lbc1, lbc2;
  smbcr_lvl_t pal, pdl, osc;
  logic [7:0] sh [0:8], dflt [0:8];
  logic [7:0] q;
  int num_errors = 0;
  int comparisons = 0;
  smbcr_if i_smbcr_if();
  smbcr_host #(.QTR_CYC(8)) i_smbcr_host (.sys_clk(sys_clk),
    .reset(reset), .bus(i_smbcr_if), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .irq(irq));
  // revision value is arbitrary
  smbcr_device #(.REVISION(4'h9)) i_smbcr_device (.sys_clk(sys_clk),
    .reset(reset), .bus(i_smbcr_if), .clock_presence_flag(flag),
    .applied_boost_ch1(b1), .applied_boost_ch2(b2),
    .applied_boost_ch3(b3), .applied_enable(en),
    .lane_boost_code0(lbc0), .lane_boost_code1(lbc1),
    .lane_boost_code2(lbc2), .clock_disable(cdis),
    .lane0_disable(l0dis), .lane1_disable(l1dis),
    .lane2_disable(l2dis), .presence_assert_level(pal),
    .presence_deassert_level(pdl), .enable_from_register(efr),
    .output_swing_code(osc));
  smbcr_asserts i_smbcr_asserts (.sys_clk(sys_clk), .reset(reset),
    .chip_select(i_smbcr_if.chip_select),
    .host_scl_oe(i_smbcr_if.host_scl_oe),
    .host_sda_oe(i_smbcr_if.host_sda_oe),
    .dev_sda_oe(i_smbcr_if.dev_sda_oe),
    .serial_clock_line(i_smbcr_if.serial_clock_line),
    .serial_data_line(i_smbcr_if.serial_data_line));
  // ---------------------------------------------
  // tasks
  // ---------------------------------------------
  task check(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one single transfer; read data lands in w
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge sys_clk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'h1);
    w = hrdata;
  endtask
  task op(input logic rd, input logic [7:0] i, input logic [7:0] d);
    ahb(1'h1, `SMBCR_OFS_INDEX, {24'h0, i});
    ahb(1'h1, `SMBCR_OFS_WDATA, {24'h0, d});
    ahb(1'h1, `SMBCR_OFS_CTRL, {30'h0, rd, 1'h1});
    // busy may lag the go write by a cycle
    repeat (4) @(posedge sys_clk);
    do ahb(1'h0, `SMBCR_OFS_STATUS, 32'h0); while (w[0] !== 1'h0);
    check(w & 32'h2 | hresp, 32'h0);
    ahb(1'h0, `SMBCR_OFS_RDATA, 32'h0);
    q = w[7:0];
  endtask
  task rd_all;
    for (int i = 0; i < 9; i++) begin
      op(1'h1, i[7:0], 8'h0);
      check({24'h0, q}, {24'h0, sh[i]});
    end
    check({12'h0, lbc0, lbc1, lbc2, l0dis, cdis, l2dis, l1dis, pal, pdl,
      efr, osc}, {12'h0, sh[3][6:4], sh[4][2:0], sh[4][6:4], sh[3][7],
      sh[3][3], sh[4][7], sh[4][3], sh[5][1:0], sh[6][1:0], sh[7][0],
      sh[8][3:2]});
  endtask
  task conclude;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ---------------------------------------------
  // clock, watchdog, tests
  // ---------------------------------------------
  initial forever #2.5 sys_clk = ~sys_clk;
  initial begin
    repeat (90000) @(posedge sys_clk);
    num_errors++;
    conclude;
  end
  initial begin
    sh = '{8'h91, 8'h58, 8'h62, `SMBCR_RST_CLK_LANE0, `SMBCR_RST_LANE12,
      `SMBCR_RST_ON_LEVEL, `SMBCR_RST_OFF_LEVEL, `SMBCR_RST_EN_SOURCE,
      `SMBCR_RST_SWING};
    dflt = sh;
    repeat (12) @(posedge sys_clk);
    reset <= 1'h0;
    repeat (8) @(posedge sys_clk);
    rd_all;
    $display("test defaults done");
    // read-only and out-of-range indices must not store
    for (int i = 0; i < 10; i++) begin
      op(1'h0, i[7:0], 8'hA5 ^ i[7:0]);
      if (i > 2 && i < 9)
        sh[i] = 8'hA5 ^ i[7:0];
    end
    rd_all;
    $display("test write all done");
    ahb(1'h1, `SMBCR_OFS_IRQ_STAT, 32'h3);
    ahb(1'h1, `SMBCR_OFS_IRQ_MASK, 32'h1);
    flag <= 1'h0;
    sh[0] = 8'h90;
    op(1'h0, `SMBCR_IDX_EN_SOURCE, 8'h01);
    sh[7] = 8'h01;
    check({31'h0, irq}, 32'h1);
    // standby through registers; port must keep answering
    op(1'h0, `SMBCR_IDX_CLK_LANE0, 8'h08);
    sh[3] = 8'h08;
    ahb(1'h1, `SMBCR_OFS_IRQ_STAT, 32'h1);
    @(posedge sys_clk);
    check({31'h0, irq}, 32'h0);
    ahb(1'h1, `SMBCR_OFS_IRQ_MASK, 32'h0);
    rd_all;
    ahb(1'h0, `SMBCR_OFS_IRQ_STAT, 32'h0);
    check(w & 32'h3, 32'h1);
    check({31'h0, irq}, 32'h0);
    $display("test standby and interrupt done");
    flag <= 1'h1;
    reset <= 1'h1;
    repeat (12) @(posedge sys_clk);
    reset <= 1'h0;
    sh = dflt;
    repeat (8) @(posedge sys_clk);
    rd_all;
    $display("test mid-run reset done");
    conclude;
  end
endmodule
